// ===== src/vesr_router.sv
// What this block does
// - status low at index 00h, read only, resets to zero
// - status low bit 7 is standby supply out of limits
// - status low bits 6..0 are analog inputs 6..0 out of limits
// - status high at index 01h, resets to zero, bits 7..6 reserved
// - status high bits 5..3: temperature channel 3..1 shutdown or limit event
// - status high bits 2..0: analog supply, battery, main supply out of limits
// - read/write enable registers at 02h and 03h mirror status layout
// - enable low: bit 7 standby, bits 6..0 inputs, reset disabled
// - enable high bits 5..3 temperature 3..1, bits 7..6 reserved, reset 0
// - enable high bits 2..0 analog supply, battery, main supply, reset 0
// - interrupt asserted when any status bit and its enable both set
`timescale 1ns/10ps

module vesr_router
(
    // clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // axi4-lite write address
    input  wire logic [vesr_pkg::VESR_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    // axi4-lite write response
    output logic      [1:0]                    s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    // axi4-lite read address
    input  wire logic [vesr_pkg::VESR_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    // axi4-lite read data
    output logic      [31:0]                   s_axi_rdata,
    output logic      [1:0]                    s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // channel flags from the monitor
    input  wire logic [7:0]                    low_high_limit_flag,
    input  wire logic [7:0]                    low_low_limit_flag,
    input  wire logic [2:0]                    sup_high_limit_flag,
    input  wire logic [2:0]                    sup_low_limit_flag,
    input  wire logic [2:0]                    temp_high_limit_flag,
    input  wire logic [2:0]                    temp_low_limit_flag,
    input  wire logic [2:0]                    temp_overtemp_shutdown,
    // interrupts
    output logic                               management_interrupt_n,
    output logic                               irq
);
    import vesr_pkg::*;

    // --------------------------------------------------------------------
    // timing at the ports
    // --------------------------------------------------------------------
    // write channel:
    //   halves are taken alone, either order
    //   a held half drops its ready, so a
    //   second write stalls on the bus
    //   rather than overwrite the held half
    //   one edge after both halves are held
    //   the word is updated and bvalid rises
    //   bvalid stands until bready is seen
    //   only lane 0 carries register bits
    //   lane 0 off: answered, no effect
    //   status words: answered, dropped
    // read channel:
    //   address taken while no reply waits
    //   reply registered one edge later
    //   arready low while the reply stands,
    //   so one read at most is in flight
    //   status is taken at the taking edge;
    //   a later flag shows in the next read
    //   rdata above bit 7 is always zero
    //   the clear word reads back zero
    // refused places:
    //   indices above the irq enable word
    //   answer SLVERR with zero data, and
    //   a write there changes nothing
    // alarm path:
    //   status is a plain or of the flags,
    //   not latched: only clearing the
    //   flags at the monitor clears it
    //   reserved enable bits are masked on
    //   write, so they read zero and never
    //   route a reserved status bit
    //   routed alarm is registered once
    //   before the pin, keeping glitches of
    //   the flag inputs off the host line;
    //   the price is one cycle of latency
    //   pin is active low, idles high
    // event interrupt:
    //   a second, active-high line reports
    //   edges of the routed alarm
    //   bit 0: alarm went active
    //   bit 1: alarm went away
    //   the irq enable word gates each bit
    //   bits stick until written with one
    //   at the clear word; an edge in the
    //   clear cycle wins, so none is lost
    //   the line is combinational from
    //   registered status and enable
    // reset:
    //   synchronous; enables and event
    //   bits return to zero, pin released
    //   first request may be shown on the
    //   first edge after release

    // --------------------------------------------------------------------
    // state
    // --------------------------------------------------------------------
    typedef struct packed {
        logic [VESR_ADDR_W-1:0] awaddr;
        logic                   aw_held;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   w_held;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
        logic [7:0]             enable_low;
        logic [7:0]             enable_high;
        logic [VESR_IRQ_BITS-1:0] irq_status;
        logic [VESR_IRQ_BITS-1:0] irq_enable;
        logic                   mgmt_prev;
        logic                   mgmt_n;
    } vesr_state_s;

    vesr_state_s state;
    vesr_state_s next_state;

    logic [7:0] summary_low;
    logic [7:0] summary_high;
    logic       mgmt_active;
    logic       write_fire;
    logic       read_fire;

    // --------------------------------------------------------------------
    // event summary
    // --------------------------------------------------------------------
    vesr_event_summary vesr_event_summary_inst
    (
        .low_high_limit_flag    (low_high_limit_flag),
        .low_low_limit_flag     (low_low_limit_flag),
        .sup_high_limit_flag    (sup_high_limit_flag),
        .sup_low_limit_flag     (sup_low_limit_flag),
        .temp_high_limit_flag   (temp_high_limit_flag),
        .temp_low_limit_flag    (temp_low_limit_flag),
        .temp_overtemp_shutdown (temp_overtemp_shutdown),
        .summary_low            (summary_low),
        .summary_high           (summary_high)
    );

    // word address to register index; unmapped returns an out-of-range marker
    function automatic logic [4:0] reg_index(input logic [VESR_ADDR_W-1:0] addr);
        reg_index = {1'b0, addr[VESR_ADDR_W-1:2]};
        if (addr[VESR_ADDR_W-1:2] > VESR_IDX_IRQ_ENABLE)
            reg_index = 5'h10;
    endfunction

    // --------------------------------------------------------------------
    // interrupt combine
    // --------------------------------------------------------------------
    // any status bit gated by its own enable bit
    assign mgmt_active = |(summary_low & state.enable_low)
                       | |(summary_high & state.enable_high);

    assign write_fire = state.aw_held && state.w_held && !state.bvalid;
    assign read_fire  = s_axi_arvalid && !state.rvalid;

    // --------------------------------------------------------------------
    // next state
    // --------------------------------------------------------------------
    always_comb
    begin
        logic [4:0]               widx;
        logic [4:0]               ridx;
        logic [VESR_IRQ_BITS-1:0] irq_set;
        logic [VESR_IRQ_BITS-1:0] irq_clr;
        widx       = reg_index(state.awaddr);
        ridx       = reg_index(s_axi_araddr);
        irq_set    = '0;
        irq_clr    = '0;
        next_state = state;

        // capture address and data independently, in either order
        if (s_axi_awvalid && !state.aw_held)
        begin
            next_state.awaddr  = s_axi_awaddr;
            next_state.aw_held = 1'b1;
        end
        if (s_axi_wvalid && !state.w_held)
        begin
            next_state.wdata  = s_axi_wdata;
            next_state.wstrb  = s_axi_wstrb;
            next_state.w_held = 1'b1;
        end

        // perform a write once both halves are in
        if (write_fire)
        begin
            next_state.aw_held = 1'b0;
            next_state.w_held  = 1'b0;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = VESR_RESP_OKAY;
            unique case (widx)
                {1'b0, VESR_IDX_STATUS_LOW},
                {1'b0, VESR_IDX_STATUS_HIGH}: ;
                {1'b0, VESR_IDX_ENABLE_LOW}:
                    if (state.wstrb[0])
                        next_state.enable_low = state.wdata[7:0];
                {1'b0, VESR_IDX_ENABLE_HIGH}:
                    if (state.wstrb[0])
                        next_state.enable_high = state.wdata[7:0] & VESR_HIGH_MASK;
                {1'b0, VESR_IDX_IRQ_STATUS}: ;
                {1'b0, VESR_IDX_IRQ_CLEAR}:
                    if (state.wstrb[0])
                        irq_clr = state.wdata[VESR_IRQ_BITS-1:0];
                {1'b0, VESR_IDX_IRQ_ENABLE}:
                    if (state.wstrb[0])
                        next_state.irq_enable = state.wdata[VESR_IRQ_BITS-1:0];
                default:
                    next_state.bresp = VESR_RESP_SLVERR;
            endcase
        end
        if (state.bvalid && s_axi_bready)
            next_state.bvalid = 1'b0;

        // read: register the answer one cycle after the address is taken
        if (read_fire)
        begin
            next_state.rvalid = 1'b1;
            next_state.rresp  = VESR_RESP_OKAY;
            next_state.rdata  = '0;
            unique case (ridx)
                {1'b0, VESR_IDX_STATUS_LOW}:  next_state.rdata[7:0] = summary_low;
                {1'b0, VESR_IDX_STATUS_HIGH}: next_state.rdata[7:0] = summary_high;
                {1'b0, VESR_IDX_ENABLE_LOW}:  next_state.rdata[7:0] = state.enable_low;
                {1'b0, VESR_IDX_ENABLE_HIGH}: next_state.rdata[7:0] = state.enable_high;
                {1'b0, VESR_IDX_IRQ_STATUS}:
                    next_state.rdata[VESR_IRQ_BITS-1:0] = state.irq_status;
                {1'b0, VESR_IDX_IRQ_CLEAR}: ;                                     // write only
                {1'b0, VESR_IDX_IRQ_ENABLE}:
                    next_state.rdata[VESR_IRQ_BITS-1:0] = state.irq_enable;
                default:
                    next_state.rresp = VESR_RESP_SLVERR;
            endcase
        end
        else if (state.rvalid && s_axi_rready)
            next_state.rvalid = 1'b0;

        // sticky events: bit 0 rising, bit 1 falling edge of the routed alarm
        irq_set[0] = mgmt_active && !state.mgmt_prev;
        irq_set[1] = !mgmt_active && state.mgmt_prev;
        // set wins over a clear in the same cycle
        next_state.irq_status = (state.irq_status & ~irq_clr) | irq_set;
        next_state.mgmt_prev  = mgmt_active;

        // registered active-low output, one cycle behind the combine
        next_state.mgmt_n = !mgmt_active;
    end

    // --------------------------------------------------------------------
    // registers
    // --------------------------------------------------------------------
    // synchronous reset: all routing disabled, interrupt released
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state             <= '0;
            state.enable_low  <= VESR_ENABLE_RESET;
            state.enable_high <= VESR_ENABLE_RESET;
            state.irq_status  <= VESR_IRQ_RESET;
            state.irq_enable  <= VESR_IRQ_RESET;
            state.mgmt_n      <= 1'b1;
        end
        else
            state <= next_state;
    end

    // --------------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------------
    // ready held low while a half waits, so a second write stalls
    assign s_axi_awready          = !state.aw_held;
    assign s_axi_wready           = !state.w_held;
    assign s_axi_bvalid           = state.bvalid;
    assign s_axi_bresp            = state.bresp;
    assign s_axi_arready          = !state.rvalid;
    assign s_axi_rvalid           = state.rvalid;
    assign s_axi_rdata            = state.rdata;
    assign s_axi_rresp            = state.rresp;
    assign management_interrupt_n = state.mgmt_n;
    assign irq                    = |(state.irq_status & state.irq_enable);

endmodule // vesr_router

// ===== src/vesr_pkg.sv
package vesr_pkg;

    // --------------------------------------------------------------------
    // register map: printed offsets 00h..03h are not all multiples of 4,
    // so they are indices and the byte address is four times the index
    // --------------------------------------------------------------------
    localparam logic [3:0] VESR_IDX_STATUS_LOW  = 4'h0;
    localparam logic [3:0] VESR_IDX_STATUS_HIGH = 4'h1;
    localparam logic [3:0] VESR_IDX_ENABLE_LOW  = 4'h2;
    localparam logic [3:0] VESR_IDX_ENABLE_HIGH = 4'h3;
    localparam logic [3:0] VESR_IDX_IRQ_STATUS  = 4'h4;
    localparam logic [3:0] VESR_IDX_IRQ_CLEAR   = 4'h5;
    localparam logic [3:0] VESR_IDX_IRQ_ENABLE  = 4'h6;
    localparam int         VESR_ADDR_W          = 6;

    // --------------------------------------------------------------------
    // field layout and reset values
    // --------------------------------------------------------------------
    localparam int         VESR_LOW_BITS      = 8;
    localparam int         VESR_HIGH_BITS     = 6;
    localparam logic [7:0] VESR_HIGH_MASK     = 8'h3F;
    localparam logic [7:0] VESR_ENABLE_RESET  = 8'h00;
    localparam int         VESR_TEMP_CHANNELS = 3;
    localparam int         VESR_IRQ_BITS      = 2;
    localparam logic [1:0] VESR_IRQ_RESET     = 2'h0;

    // axi response codes
    localparam logic [1:0] VESR_RESP_OKAY   = 2'h0;
    localparam logic [1:0] VESR_RESP_SLVERR = 2'h2;

endpackage // vesr_pkg

// ===== src/vesr_event_summary.sv
`timescale 1ns/10ps

// --------------------------------------------------------------------
// per-channel flag summary
// --------------------------------------------------------------------
module vesr_event_summary
(
    // per-channel limit flags, low status group
    input  wire logic [7:0] low_high_limit_flag,
    input  wire logic [7:0] low_low_limit_flag,
    // analog supply, battery, main supply
    input  wire logic [2:0] sup_high_limit_flag,
    input  wire logic [2:0] sup_low_limit_flag,
    // temperature channels 3..1 as bits 2..0
    input  wire logic [2:0] temp_high_limit_flag,
    input  wire logic [2:0] temp_low_limit_flag,
    input  wire logic [2:0] temp_overtemp_shutdown,
    // summaries
    output logic      [7:0] summary_low,
    output logic      [7:0] summary_high
);
    import vesr_pkg::*;

    // pure or of the flags, so a bit drops as soon as host clears flags
    always_comb
    begin
        summary_low  = low_high_limit_flag | low_low_limit_flag;
        summary_high = {2'h0,
                        temp_high_limit_flag | temp_low_limit_flag
                            | temp_overtemp_shutdown,
                        sup_high_limit_flag | sup_low_limit_flag};
    end

endmodule // vesr_event_summary

// ===== dv/vesr_router_checker.sv
`timescale 1ns/10ps

// ------------------------------------------------------------
// read bus and alarm checks at the router ports
// ------------------------------------------------------------
module vesr_router_checker
(
    // clock and reset
    input wire logic                              aclk,
    input wire logic                              aresetn,
    // read bus
    input wire logic [vesr_pkg::VESR_ADDR_W-1:0]  s_axi_araddr,
    input wire logic                              s_axi_arvalid,
    input wire logic                              s_axi_arready,
    input wire logic [31:0]                       s_axi_rdata,
    input wire logic [1:0]                        s_axi_rresp,
    input wire logic                              s_axi_rvalid,
    input wire logic                              s_axi_rready,
    // channel flags and alarm
    input wire logic [7:0]                        low_high_limit_flag,
    input wire logic [7:0]                        low_low_limit_flag,
    input wire logic [2:0]                        sup_high_limit_flag,
    input wire logic [2:0]                        sup_low_limit_flag,
    input wire logic [2:0]                        temp_high_limit_flag,
    input wire logic [2:0]                        temp_low_limit_flag,
    input wire logic [2:0]                        temp_overtemp_shutdown,
    input wire logic                              management_interrupt_n
);
    import vesr_pkg::*;

    logic [VESR_ADDR_W-1:0] raddr_q;
    logic [7:0]             sum_low;
    logic [7:0]             sum_high;

    // summaries the status registers must show
    assign sum_low  = low_high_limit_flag | low_low_limit_flag;
    assign sum_high = {2'h0, temp_high_limit_flag | temp_low_limit_flag | temp_overtemp_shutdown,
                       sup_high_limit_flag | sup_low_limit_flag};

    // the reply carries no address, so keep the one taken
    always_ff @(posedge aclk)
        if (s_axi_arvalid && s_axi_arready)
            raddr_q <= s_axi_araddr;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_RESET_IDLE: assert property ($rose(aresetn) |-> management_interrupt_n && !s_axi_rvalid)
        else $error("alarm or read reply active after reset");
    AST_QUIET_NO_ALARM: assert property (!(|{sum_low, sum_high}) |=> management_interrupt_n)
        else $error("alarm with no channel flag set");
    AST_READ_TAKEN: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read reply one cycle after address");
    AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read reply dropped or changed before taken");
    AST_ARREADY_LOW: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address accepted while reply pending");
    AST_STATUS_LOW: assert property ($rose(s_axi_rvalid) && raddr_q == 6'h00 |->
        s_axi_rdata == {24'h0, $past(sum_low)})
        else $error("low status differs from channel flags");
    AST_STATUS_HIGH: assert property ($rose(s_axi_rvalid) && raddr_q == 6'h04 |->
        s_axi_rdata == {24'h0, $past(sum_high)})
        else $error("high status differs from channel flags");
    AST_UNMAPPED: assert property ($rose(s_axi_rvalid) && raddr_q[5:2] > 4'h6 |->
        s_axi_rresp == VESR_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");

    COV_READ: cover property (s_axi_rvalid && s_axi_rready);
    COV_ALARM: cover property ($fell(management_interrupt_n));
    COV_REFUSED: cover property (s_axi_rvalid && s_axi_rresp == VESR_RESP_SLVERR);
endmodule // vesr_router_checker

bind vesr_router vesr_router_checker vesr_router_checker_inst (.*);

// ===== dv/vesr_monitor_model.sv
`timescale 1ns/10ps

// ------------------------------------------------------------
// channel flag source standing in for the monitor
// ------------------------------------------------------------
module vesr_monitor_model
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // raise and write-one clear, one bit per flag
    input  wire logic [30:0] raise,
    input  wire logic [30:0] clear,
    // flags toward the router
    output logic      [7:0]  low_high_limit_flag,
    output logic      [7:0]  low_low_limit_flag,
    output logic      [2:0]  sup_high_limit_flag,
    output logic      [2:0]  sup_low_limit_flag,
    output logic      [2:0]  temp_high_limit_flag,
    output logic      [2:0]  temp_low_limit_flag,
    output logic      [2:0]  temp_overtemp_shutdown
);
    logic [30:0] flags;

    // flags stick until the host writes one; clear wins over a raise
    always_ff @(posedge aclk)
        if (!aresetn)
            flags <= 31'h0;
        else
            flags <= (flags | raise) & ~clear;

    // slice order is the bench's flag vector
    assign low_high_limit_flag    = flags[7:0];
    assign low_low_limit_flag     = flags[15:8];
    assign sup_high_limit_flag    = flags[18:16];
    assign sup_low_limit_flag     = flags[21:19];
    assign temp_high_limit_flag   = flags[24:22];
    assign temp_low_limit_flag    = flags[27:25];
    assign temp_overtemp_shutdown = flags[30:28];
endmodule // vesr_monitor_model

// ===== dv/voltage_event_smi_router_tb_top.sv
`timescale 1ns/10ps

// ------------------------------------------------------------
// bench top
// ------------------------------------------------------------
module voltage_event_smi_router_tb_top;
    import vesr_pkg::*;

    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, management_interrupt_n, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb;
    logic [5:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [7:0]  low_high_limit_flag, low_low_limit_flag;
    logic [2:0]  sup_high_limit_flag, sup_low_limit_flag, temp_high_limit_flag;
    logic [2:0]  temp_low_limit_flag, temp_overtemp_shutdown;
    logic [30:0] raise, clear;
    logic [15:0] st;
    int          num_errors, cmp_count, cyc, i;

    vesr_router        vesr_router_inst (.*);
    vesr_monitor_model vesr_monitor_model_inst (.*);

    // 125 MHz
    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic finish_test();
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // a hung handshake ends here as a mismatch
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            num_errors++;
            finish_test();
        end
    end

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t: data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t: pin %b expected %b", $time, got, exp);
        end
    endtask

    // write: both halves offered together, each dropped once taken
    task automatic wr_chk(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_done;
        logic w_done;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        aw_done = 1'b0;
        w_done  = 1'b0;
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            aw_done = aw_done || s_axi_awready === 1'b1;
            w_done  = w_done || s_axi_wready === 1'b1;
            s_axi_awvalid <= !aw_done;
            s_axi_wvalid  <= !w_done;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk_data({30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk_data(s_axi_rdata, ed);
        chk_data({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    // one-cycle raise or clear at the monitor, then let the alarm settle
    task automatic flag(input logic [30:0] r, input logic [30:0] c);
        @(posedge aclk);
        raise <= r;
        clear <= c;
        @(posedge aclk);
        raise <= 31'h0;
        clear <= 31'h0;
        repeat (3) @(posedge aclk);
    endtask

    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, raise, clear} <= '0;
        s_axi_wstrb <= 4'hF;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 4; i++)
            rd_chk(6'(4 * i), 32'h0, VESR_RESP_OKAY);
        chk_pin(management_interrupt_n, 1'b1);
        wr_chk(6'h00, 32'hFF, VESR_RESP_OKAY);
        wr_chk(6'h04, 32'hFF, VESR_RESP_OKAY);
        wr_chk(6'h08, 32'hFF, VESR_RESP_OKAY);
        wr_chk(6'h0C, 32'hFFFFFFFF, VESR_RESP_OKAY);
        rd_chk(6'h00, 32'h0, VESR_RESP_OKAY);
        rd_chk(6'h04, 32'h0, VESR_RESP_OKAY);
        rd_chk(6'h08, 32'hFF, VESR_RESP_OKAY);
        rd_chk(6'h0C, 32'h3F, VESR_RESP_OKAY);
        // lane 0 off: the write is answered but lands nowhere
        s_axi_wstrb <= 4'h0;
        wr_chk(6'h08, 32'h0, VESR_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd_chk(6'h08, 32'hFF, VESR_RESP_OKAY);
        // each flag alone: its status bit, the alarm, then the host clear
        for (i = 0; i < 31; i++)
        begin
            flag(31'h1 << i, 31'h0);
            st = 16'(((1 << i) >> 8) | (1 << i)) & 16'h00FF;
            st[15:8] = {2'h0, 3'(((1 << i) >> 22) | ((1 << i) >> 25) | ((1 << i) >> 28)),
                        3'(((1 << i) >> 16) | ((1 << i) >> 19))};
            rd_chk(6'h00, {24'h0, st[7:0]}, VESR_RESP_OKAY);
            rd_chk(6'h04, {24'h0, st[15:8]}, VESR_RESP_OKAY);
            chk_pin(management_interrupt_n, 1'b0);
            flag(31'h0, 31'h1 << i);
            rd_chk(6'h00, 32'h0, VESR_RESP_OKAY);
            rd_chk(6'h04, 32'h0, VESR_RESP_OKAY);
            chk_pin(management_interrupt_n, 1'b1);
        end
        // event interrupt: clear, enable, masked channel raises nothing
        wr_chk(6'h14, 32'h3, VESR_RESP_OKAY);
        wr_chk(6'h18, 32'h1, VESR_RESP_OKAY);
        wr_chk(6'h08, 32'h7F, VESR_RESP_OKAY);
        flag(31'h80, 31'h0);
        chk_pin(management_interrupt_n, 1'b1);
        chk_pin(irq, 1'b0);
        wr_chk(6'h08, 32'hFF, VESR_RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk_pin(management_interrupt_n, 1'b0);
        chk_pin(irq, 1'b1);
        rd_chk(6'h10, 32'h1, VESR_RESP_OKAY);
        wr_chk(6'h18, 32'h0, VESR_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk_pin(irq, 1'b0);
        wr_chk(6'h18, 32'h1, VESR_RESP_OKAY);
        wr_chk(6'h14, 32'h1, VESR_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk_pin(irq, 1'b0);
        rd_chk(6'h10, 32'h0, VESR_RESP_OKAY);
        // releasing the alarm marks the falling event bit
        flag(31'h0, 31'h80);
        chk_pin(management_interrupt_n, 1'b1);
        rd_chk(6'h10, 32'h2, VESR_RESP_OKAY);
        // unmapped place refused, clear register reads zero
        rd_chk(6'h1C, 32'h0, VESR_RESP_SLVERR);
        wr_chk(6'h1C, 32'h1, VESR_RESP_SLVERR);
        rd_chk(6'h14, 32'h0, VESR_RESP_OKAY);
        // second reset drops the enables again
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(6'h08, 32'h0, VESR_RESP_OKAY);
        rd_chk(6'h0C, 32'h0, VESR_RESP_OKAY);
        finish_test();
    end
endmodule // voltage_event_smi_router_tb_top
